// File: rvm_top.sv
// Regulator voltage monitor: eight channels of low and high fault supervision.
// Assumes comparator and power-good inputs are asynchronous pins; APB on clk_sys_i.
// Functional notes
// - eight independent low and high channels
// - low trip code maps 95 to 89 percent
// - high trip code maps 105 to 111 percent
// - shared low filter time, 5 to 40 us
// - low filter time resets to code two
// - shared high filter time, 25 to 125 us
// - high filter time resets to code zero
// - per-regulator enable gates its monitoring
// - all enables start at one
// - protected enables need a secure write
// - mask faults until regulator in regulation
// - disabled monitor forces statuses to zero
// - ignore comparators during settling after enable
`timescale 1ns/1ps
`default_nettype none
module rvm_top #(
  parameter int NCH = rvm_pkg::NCH
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // APB slave.
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Analog comparator and regulator inputs, asynchronous.
  input wire logic [NCH-1:0] low_cmp_i,
  input wire logic [NCH-1:0] high_cmp_i,
  input wire logic [NCH-1:0] reg_on_i,
  input wire logic [NCH-1:0] reg_good_i,
  // One-time-programmed trip codes, two bits per channel (buck 0..4, linreg 5..7).
  input wire logic [2*NCH-1:0] low_trip_code_i,
  input wire logic [2*NCH-1:0] high_trip_code_i,
  // Trip levels to the analog comparators, in percent of nominal.
  output logic [NCH*7-1:0] low_trip_pct_o,
  output logic [NCH*7-1:0] high_trip_pct_o,
  // Comparator enables to the analog side, and status.
  output logic [NCH-1:0] cmp_enable_o,
  output logic [NCH-1:0] low_fault_status_o,
  output logic [NCH-1:0] high_fault_status_o,
  output logic irq_o
);
  typedef enum logic [1:0] {RVM_OFF, RVM_SETTLE, RVM_WAIT_GOOD, RVM_WATCH} rvm_state_t;

  // Registers.
  logic [1:0] low_fault_filter_time;
  logic [1:0] high_fault_filter_time;
  logic [NCH-1:0] monitor_enable;
  logic secure_prot;
  logic [2*NCH-1:0] irq_stat;
  logic [2*NCH-1:0] irq_en;
  // Synchronisers, three stages.
  logic [NCH-1:0] low_s1, low_s2, low_s3;
  logic [NCH-1:0] high_s1, high_s2, high_s3;
  logic [NCH-1:0] on_s1, on_s2, on_s3;
  logic [NCH-1:0] good_s1, good_s2, good_s3;
  logic [NCH-1:0] low_q, high_q, on_q, good_q;
  // Per-channel state.
  rvm_state_t state [NCH];
  logic [11:0] settle_cnt [NCH];
  logic [NCH-1:0] watching;
  logic [NCH-1:0] low_flag, high_flag;
  logic [NCH-1:0] low_flag_d, high_flag_d;
  logic [11:0] low_limit, high_limit;
  logic wr_en, rd_en, secure_ok, addr_ok;
  logic [31:0] next_prdata;

  // ==========================================================================
  // Trip code decode.
  function automatic logic [6:0] low_pct(input logic [1:0] code);
    low_pct = 7'(95 - 2 * int'(code));
  endfunction
  function automatic logic [6:0] high_pct(input logic [1:0] code);
    high_pct = 7'(105 + 2 * int'(code));
  endfunction

  // Levels are flopped so the analog trims see no glitches from code changes.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      low_trip_pct_o <= '0;
      high_trip_pct_o <= '0;
    end else begin
      for (int i = 0; i < NCH; i++) begin
        low_trip_pct_o[i*7 +: 7] <= low_pct(low_trip_code_i[2*i +: 2]);
        high_trip_pct_o[i*7 +: 7] <= high_pct(high_trip_code_i[2*i +: 2]);
      end
    end
  end

  // ==========================================================================
  // Filter time selection, shared by all channels.
  always_comb begin
    case (low_fault_filter_time)
      2'h0: low_limit = rvm_pkg::LOW_C0;
      2'h1: low_limit = rvm_pkg::LOW_C1;
      2'h2: low_limit = rvm_pkg::LOW_C2;
      default: low_limit = rvm_pkg::LOW_C3;
    endcase
    case (high_fault_filter_time)
      2'h0: high_limit = rvm_pkg::HIGH_C0;
      2'h1: high_limit = rvm_pkg::HIGH_C1;
      2'h2: high_limit = rvm_pkg::HIGH_C2;
      default: high_limit = rvm_pkg::HIGH_C3;
    endcase
  end

  // ==========================================================================
  // Input synchronisers; a change counts once stages two and three agree.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      {low_s1, low_s2, low_s3} <= '0;
      {high_s1, high_s2, high_s3} <= '0;
      {on_s1, on_s2, on_s3} <= '0;
      {good_s1, good_s2, good_s3} <= '0;
      {low_q, high_q, on_q, good_q} <= '0;
    end else begin
      low_s1 <= low_cmp_i;
      low_s2 <= low_s1;
      low_s3 <= low_s2;
      high_s1 <= high_cmp_i;
      high_s2 <= high_s1;
      high_s3 <= high_s2;
      on_s1 <= reg_on_i;
      on_s2 <= on_s1;
      on_s3 <= on_s2;
      good_s1 <= reg_good_i;
      good_s2 <= good_s1;
      good_s3 <= good_s2;
      for (int i = 0; i < NCH; i++) begin
        if (low_s2[i] == low_s3[i]) low_q[i] <= low_s3[i];
        if (high_s2[i] == high_s3[i]) high_q[i] <= high_s3[i];
        if (on_s2[i] == on_s3[i]) on_q[i] <= on_s3[i];
        if (good_s2[i] == good_s3[i]) good_q[i] <= good_s3[i];
      end
    end
  end

  // ==========================================================================
  // Per-channel sequencing: off, settle after enable, wait for regulation, watch.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < NCH; i++) begin
        state[i] <= RVM_OFF;
        settle_cnt[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        case (state[i])
          RVM_OFF: begin
            settle_cnt[i] <= '0;
            if (monitor_enable[i]) state[i] <= RVM_SETTLE;
          end
          RVM_SETTLE: begin
            settle_cnt[i] <= settle_cnt[i] + 12'h001;
            if (!monitor_enable[i]) state[i] <= RVM_OFF;
            else if (settle_cnt[i] + 12'h001 >= rvm_pkg::SETTLE_C) state[i] <= RVM_WAIT_GOOD;
          end
          RVM_WAIT_GOOD: begin
            if (!monitor_enable[i]) state[i] <= RVM_OFF;
            else if (on_q[i] && good_q[i]) state[i] <= RVM_WATCH;
          end
          RVM_WATCH: begin
            if (!monitor_enable[i]) state[i] <= RVM_OFF;
            else if (!on_q[i]) state[i] <= RVM_WAIT_GOOD;
          end
          default: state[i] <= RVM_OFF;
        endcase
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      watching[i] = (state[i] == RVM_WATCH) && monitor_enable[i];
      cmp_enable_o[i] = (state[i] != RVM_OFF);
    end
  end

  // ==========================================================================
  // Debounce filters, two per channel.
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    rvm_filter #(.W(rvm_pkg::CNT_W)) u_low (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .active_i(watching[g] && low_q[g]),
      .limit_i(low_limit),
      .flag_o(low_flag[g])
    );
    rvm_filter #(.W(rvm_pkg::CNT_W)) u_high (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .active_i(watching[g] && high_q[g]),
      .limit_i(high_limit),
      .flag_o(high_flag[g])
    );
  end

  // Disabling forces status to zero at once, not one filter cycle later.
  assign low_fault_status_o = low_flag & monitor_enable;
  assign high_fault_status_o = high_flag & monitor_enable;

  // ==========================================================================
  // APB decode; zero wait states, unmapped offsets answer with an error.
  assign pready_o = 1'b1;
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && !penable_i && !pwrite_i;
  assign secure_ok = (pwdata_i[31:rvm_pkg::SEC_KEY_LSB] == rvm_pkg::SEC_KEY);

  always_comb begin
    case (paddr_i)
      rvm_pkg::OFS_CTRL, rvm_pkg::OFS_ENABLE, rvm_pkg::OFS_SECURE, rvm_pkg::OFS_STATUS,
      rvm_pkg::OFS_IRQ_STAT, rvm_pkg::OFS_IRQ_EN, rvm_pkg::OFS_IRQ_CLR, rvm_pkg::OFS_TRIP: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr_o = psel_i && penable_i && !addr_ok;

  // Control registers.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      low_fault_filter_time <= rvm_pkg::LOW_FILT_RST;
      high_fault_filter_time <= rvm_pkg::HIGH_FILT_RST;
      monitor_enable <= rvm_pkg::MON_EN_RST;
      secure_prot <= 1'b0;
      irq_en <= '0;
    end else if (wr_en) begin
      case (paddr_i)
        rvm_pkg::OFS_CTRL: begin
          low_fault_filter_time <= pwdata_i[rvm_pkg::CTRL_LOW_LSB +: 2];
          high_fault_filter_time <= pwdata_i[rvm_pkg::CTRL_HIGH_LSB +: 2];
        end
        rvm_pkg::OFS_ENABLE: begin
          // A protected enable needs the key in the upper half of the same word.
          if (!secure_prot || secure_ok) monitor_enable <= pwdata_i[NCH-1:0];
        end
        rvm_pkg::OFS_SECURE: secure_prot <= pwdata_i[rvm_pkg::SEC_PROT_BIT];
        rvm_pkg::OFS_IRQ_EN: irq_en <= pwdata_i[2*NCH-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Sticky event bits on each rising status; a new event wins over a clear.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      low_flag_d <= '0;
      high_flag_d <= '0;
      irq_stat <= '0;
    end else begin
      low_flag_d <= low_fault_status_o;
      high_flag_d <= high_fault_status_o;
      irq_stat <= (irq_stat & ~((wr_en && paddr_i == rvm_pkg::OFS_IRQ_CLR) ? pwdata_i[2*NCH-1:0] : '0))
        | {high_fault_status_o & ~high_flag_d, low_fault_status_o & ~low_flag_d};
    end
  end
  assign irq_o = |(irq_stat & irq_en);

  // ==========================================================================
  // Read data, registered in the setup cycle.
  always_comb begin
    next_prdata = 32'h0000_0000;
    case (paddr_i)
      rvm_pkg::OFS_CTRL: begin
        next_prdata[rvm_pkg::CTRL_LOW_LSB +: 2] = low_fault_filter_time;
        next_prdata[rvm_pkg::CTRL_HIGH_LSB +: 2] = high_fault_filter_time;
      end
      rvm_pkg::OFS_ENABLE: next_prdata[NCH-1:0] = monitor_enable;
      rvm_pkg::OFS_SECURE: next_prdata[rvm_pkg::SEC_PROT_BIT] = secure_prot;
      rvm_pkg::OFS_STATUS: next_prdata[2*NCH-1:0] = {high_fault_status_o, low_fault_status_o};
      rvm_pkg::OFS_IRQ_STAT: next_prdata[2*NCH-1:0] = irq_stat;
      rvm_pkg::OFS_IRQ_EN: next_prdata[2*NCH-1:0] = irq_en;
      rvm_pkg::OFS_TRIP: next_prdata[4*NCH-1:0] = {high_trip_code_i, low_trip_code_i};
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) prdata_o <= 32'h0000_0000;
    else if (rd_en) prdata_o <= next_prdata;
  end

  // ==========================================================================
  // Checks.
  chk_disabled_status_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ((low_fault_status_o | high_fault_status_o) & ~monitor_enable) == '0)
    else $error("Disabled channel shows a fault status.");
  // The filter itself must drop too, so a re-enable cannot resurrect an old fault.
  chk_disable_clears: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !monitor_enable[0] |=> !low_flag[0] && !high_flag[0])
    else $error("Channel zero filter held a flag while disabled.");
  chk_mask_before_good: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state[0] == RVM_WAIT_GOOD) |-> !watching[0])
    else $error("Channel zero watched before regulation.");
  chk_settle_length: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(state[0] == RVM_SETTLE) |-> (state[0] != RVM_WATCH)[*8])
    else $error("Channel zero watched during settling.");
  chk_protected_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_en && paddr_i == rvm_pkg::OFS_ENABLE && secure_prot && !secure_ok) |=> $stable(monitor_enable))
    else $error("Unkeyed write changed a protected enable.");
  chk_enable_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_en && paddr_i == rvm_pkg::OFS_ENABLE && !secure_prot) |=> monitor_enable == $past(pwdata_i[NCH-1:0]))
    else $error("Open enable write not stored.");
  chk_filter_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_en && paddr_i == rvm_pkg::OFS_CTRL) |=> low_fault_filter_time == $past(pwdata_i[1:0]))
    else $error("Low filter time not stored.");
  chk_low_limit_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (low_fault_filter_time == 2'h3) |-> low_limit == 12'h320)
    else $error("Low filter code three maps wrong.");
  chk_high_limit_map: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (high_fault_filter_time == 2'h3) |-> high_limit == 12'h9C4)
    else $error("High filter code three maps wrong.");
  // Levels load one edge after the code is seen, and only outside reset.
  chk_trip_levels: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rst_n_i && $stable(low_trip_code_i)) |=> low_trip_pct_o[6:0] ==
      (($past(low_trip_code_i[1:0]) == 2'h0) ? 7'h5F : ($past(low_trip_code_i[1:0]) == 2'h1) ? 7'h5D :
      ($past(low_trip_code_i[1:0]) == 2'h2) ? 7'h5B : 7'h59))
    else $error("Low trip level wrong.");
  chk_status_readable: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (rd_en && paddr_i == rvm_pkg::OFS_STATUS) |=> prdata_o[NCH-1:0] == $past(low_fault_status_o))
    else $error("Status read mismatch.");
  cov_wait_good: cover property (@(posedge clk_sys_i) state[1] == RVM_WAIT_GOOD && good_q[1]);
  cov_low_fault: cover property (@(posedge clk_sys_i) $rose(low_fault_status_o[0]));
  cov_high_fault: cover property (@(posedge clk_sys_i) $rose(high_fault_status_o[0]));
  cov_disable: cover property (@(posedge clk_sys_i) $fell(monitor_enable[0]));
  cov_irq: cover property (@(posedge clk_sys_i) $rose(irq_o));
endmodule
`default_nettype wire

// File: rvm_pkg.sv
// Package for the regulator voltage monitor: register map, reset values, timing constants.
// Assumes a 20 MHz system clock and a 32-bit APB register bus.
package rvm_pkg;
  // ==========================================================================
  // Clock and timing.
  localparam int CLK_HZ = 20000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam int NCH = 8;
  localparam int CNT_W = 12;
  // Filter times in microseconds, as coded.
  localparam int LOW_T0_US = 5;
  localparam int LOW_T1_US = 15;
  localparam int LOW_T2_US = 25;
  localparam int LOW_T3_US = 40;
  localparam int HIGH_T0_US = 25;
  localparam int HIGH_T1_US = 50;
  localparam int HIGH_T2_US = 80;
  localparam int HIGH_T3_US = 125;
  localparam int SETTLE_US = 30;
  // Cycle counts; all fit in 12 bits, the longest (high code three, 2500) included.
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam logic [11:0] LOW_C0 = 12'(LOW_T0_US * CYC_PER_US);
  localparam logic [11:0] LOW_C1 = 12'(LOW_T1_US * CYC_PER_US);
  localparam logic [11:0] LOW_C2 = 12'(LOW_T2_US * CYC_PER_US);
  localparam logic [11:0] LOW_C3 = 12'(LOW_T3_US * CYC_PER_US);
  localparam logic [11:0] HIGH_C0 = 12'(HIGH_T0_US * CYC_PER_US);
  localparam logic [11:0] HIGH_C1 = 12'(HIGH_T1_US * CYC_PER_US);
  localparam logic [11:0] HIGH_C2 = 12'(HIGH_T2_US * CYC_PER_US);
  localparam logic [11:0] HIGH_C3 = 12'(HIGH_T3_US * CYC_PER_US);
  localparam logic [11:0] SETTLE_C = 12'(SETTLE_US * CYC_PER_US);
  // ==========================================================================
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_SECURE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_TRIP = 8'h1C;
  // Control field positions.
  localparam int CTRL_LOW_LSB = 0;
  localparam int CTRL_HIGH_LSB = 4;
  localparam int SEC_PROT_BIT = 0;
  localparam int SEC_KEY_LSB = 16;
  localparam logic [15:0] SEC_KEY = 16'hA5C3;
  // Reset values.
  localparam logic [1:0] LOW_FILT_RST = 2'h2;
  localparam logic [1:0] HIGH_FILT_RST = 2'h0;
  localparam logic [7:0] MON_EN_RST = 8'hFF;
endpackage

// File: rvm_filter.sv
// One debounce filter: a qualified comparator level must hold for a full count.
// Assumes the input is already synchronised to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module rvm_filter #(
  parameter int W = 12
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Qualified condition and time limit.
  input wire logic active_i,
  input wire logic [W-1:0] limit_i,
  // Filtered status.
  output logic flag_o
);
  logic [W-1:0] count;

  // ==========================================================================
  // Counter restarts whenever the condition drops; flag clears on the next edge.
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count <= '0;
      flag_o <= 1'b0;
    end else if (!active_i) begin
      count <= '0;
      flag_o <= 1'b0;
    end else if (count + W'(1) >= limit_i) begin
      flag_o <= 1'b1;
    end else begin
      count <= count + W'(1);
    end
  end

  chk_flag_needs_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(flag_o) |-> $past(active_i, 1) && $past(active_i, 2))
    else $error("Flag rose without a held condition.");
  chk_flag_drops_fast: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !active_i |=> !flag_o)
    else $error("Flag did not drop after the condition cleared.");
endmodule
`default_nettype wire

// File: rvm_cmp_model.sv
// Behavioural model of the analog comparators beside each regulator output.
// Assumes output levels come from the bench in percent of nominal, seven bits a channel.
`timescale 1ns/1ps
`default_nettype none
module rvm_cmp_model #(
  parameter int NCH = 8
) (
  // Clock.
  input wire logic clk_sys_i,
  // Regulator output levels, trip levels and comparator enables.
  input wire logic [NCH*7-1:0] volt_pct_i,
  input wire logic [NCH*7-1:0] low_trip_pct_i,
  input wire logic [NCH*7-1:0] high_trip_pct_i,
  input wire logic [NCH-1:0] cmp_enable_i,
  // Comparator outputs, active high.
  output logic [NCH-1:0] low_cmp_o,
  output logic [NCH-1:0] high_cmp_o
);
  // ==========================================================================
  // Start quiet.
  initial begin
    low_cmp_o = '0;
    high_cmp_o = '0;
  end
  // A powered-down comparator chatters, so a monitor that trusts it would show it.
  always @(posedge clk_sys_i) begin
    for (int i = 0; i < NCH; i++) begin
      if (cmp_enable_i[i]) begin
        low_cmp_o[i] <= volt_pct_i[7*i+:7] < low_trip_pct_i[7*i+:7];
        high_cmp_o[i] <= volt_pct_i[7*i+:7] > high_trip_pct_i[7*i+:7];
      end else begin
        low_cmp_o[i] <= ~low_cmp_o[i];
        high_cmp_o[i] <= ~high_cmp_o[i];
      end
    end
  end
endmodule
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench for the regulator voltage monitor.
// Assumes rvm_pkg, rvm_top and rvm_cmp_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Signals; output levels are in percent of nominal, 100 when healthy.
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] low_cmp;
  logic [7:0] high_cmp;
  logic [7:0] reg_on = 8'hFF;
  logic [7:0] reg_good = 8'hFF;
  logic [7:0] cmp_en;
  logic [7:0] low_st;
  logic [7:0] high_st;
  logic [15:0] low_code = 16'h0000;
  logic [15:0] high_code = 16'h0000;
  logic [55:0] low_pct;
  logic [55:0] high_pct;
  logic [55:0] volt = {8{7'h64}};
  logic irq;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int check_count = 0;
  // ==========================================================================
  // Block and comparators.
  rvm_top i_rvm_top (.clk_sys_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .low_cmp_i(low_cmp), .high_cmp_i(high_cmp), .reg_on_i(reg_on),
    .reg_good_i(reg_good), .low_trip_code_i(low_code), .high_trip_code_i(high_code),
    .low_trip_pct_o(low_pct), .high_trip_pct_o(high_pct), .cmp_enable_o(cmp_en),
    .low_fault_status_o(low_st), .high_fault_status_o(high_st), .irq_o(irq));
  rvm_cmp_model i_rvm_cmp_model (.clk_sys_i(clk), .volt_pct_i(volt), .low_trip_pct_i(low_pct),
    .high_trip_pct_i(high_pct), .cmp_enable_i(cmp_en), .low_cmp_o(low_cmp), .high_cmp_o(high_cmp));
  // 20 MHz clock.
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Common tasks; outputs are sampled at the edge, before that edge's updates land.
  task automatic check(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; the request stands until pready is seen high, only the watchdog ends a wait.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(exp, rd);
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    rd_chk(rvm_pkg::OFS_CTRL, 32'h00000002);
    rd_chk(rvm_pkg::OFS_ENABLE, 32'h000000FF);
    wr(rvm_pkg::OFS_CTRL, 32'h00000033);
    rd_chk(rvm_pkg::OFS_CTRL, 32'h00000033);
    rd_chk(8'h40, 32'h00000000);
    check(32'h1, 32'(err));
    check(32'h0, 32'(irq));
  endtask
  // Every code on every channel, rotated so neighbours differ.
  task automatic t_trip;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        low_code[2*i+:2] <= 2'((i + k) % 4);
        high_code[2*i+:2] <= 2'((i + 3 * k) % 4);
      end
      cyc(4);
      for (int i = 0; i < 8; i++) begin
        check(32'(95 - 2 * ((i + k) % 4)), 32'(low_pct[7*i+:7]));
        check(32'(105 + 2 * ((i + 3 * k) % 4)), 32'(high_pct[7*i+:7]));
      end
    end
  endtask
  // A dip shorter than the filter, a gap, then a long dip on channel 0.
  task automatic t_low;
    int lim;
    lim = int'(rvm_pkg::LOW_C0);
    wr(rvm_pkg::OFS_CTRL, 32'h00000000);
    wr(rvm_pkg::OFS_IRQ_CLR, 32'h0000FFFF);
    volt[6:0] <= 7'h50;
    cyc(lim - 10);
    check(32'h0, 32'(low_st));
    volt[6:0] <= 7'h64;
    cyc(10);
    volt[6:0] <= 7'h50;
    cyc(lim - 10);
    check(32'h0, 32'(low_st));
    cyc(25);
    check(32'h1, 32'(low_st));
    rd_chk(rvm_pkg::OFS_STATUS, 32'h00000001);
    rd_chk(rvm_pkg::OFS_IRQ_STAT, 32'h00000001);
    check(32'h0, 32'(irq));
    wr(rvm_pkg::OFS_IRQ_EN, 32'h00000001);
    cyc(1);
    check(32'h1, 32'(irq));
    volt[6:0] <= 7'h64;
    cyc(12);
    check(32'h0, 32'(low_st));
    check(32'h1, 32'(irq));
    wr(rvm_pkg::OFS_IRQ_CLR, 32'h00000001);
    cyc(1);
    check(32'h0, 32'(irq));
  endtask
  // Overvoltage on channel 2 with the second high filter code.
  task automatic t_high;
    int lim;
    lim = int'(rvm_pkg::HIGH_C1);
    wr(rvm_pkg::OFS_CTRL, 32'h00000010);
    volt[20:14] <= 7'h78;
    cyc(lim - 10);
    check(32'h0, 32'(high_st));
    cyc(25);
    check(32'h4, 32'(high_st));
    volt[20:14] <= 7'h64;
    cyc(12);
    check(32'h0, 32'(high_st));
  endtask
  // Disabling clears a held fault; re-enabling waits out settling.
  task automatic t_disable;
    wr(rvm_pkg::OFS_CTRL, 32'h00000000);
    volt[6:0] <= 7'h50;
    cyc(int'(rvm_pkg::LOW_C0) + 20);
    wr(rvm_pkg::OFS_ENABLE, 32'h000000FE);
    // The channel leaves its watch state one edge after the write lands.
    cyc(2);
    check(32'h0, 32'(low_st));
    check(32'h0, 32'(cmp_en[0]));
    cyc(300);
    check(32'h0, 32'(low_st));
    wr(rvm_pkg::OFS_ENABLE, 32'h000000FF);
    cyc(int'(rvm_pkg::SETTLE_C) + int'(rvm_pkg::LOW_C0) - 10);
    check(32'h0, 32'(low_st));
    cyc(40);
    check(32'h1, 32'(low_st));
    volt[6:0] <= 7'h64;
    cyc(12);
  endtask
  // Channel 1 switched on but not yet in regulation.
  task automatic t_gate;
    reg_on[1] <= 1'b0;
    reg_good[1] <= 1'b0;
    cyc(10);
    reg_on[1] <= 1'b1;
    volt[13:7] <= 7'h50;
    cyc(400);
    check(32'h0, 32'(low_st));
    reg_good[1] <= 1'b1;
    cyc(int'(rvm_pkg::LOW_C0) + 30);
    check(32'h2, 32'(low_st));
    volt[13:7] <= 7'h64;
    cyc(12);
  endtask
  // Protected enables: a plain write is ignored, a keyed write lands.
  task automatic t_secure;
    wr(rvm_pkg::OFS_SECURE, 32'h00000001);
    wr(rvm_pkg::OFS_ENABLE, 32'h00000000);
    rd_chk(rvm_pkg::OFS_ENABLE, 32'h000000FF);
    wr(rvm_pkg::OFS_ENABLE, {rvm_pkg::SEC_KEY, 16'h007F});
    rd_chk(rvm_pkg::OFS_ENABLE, 32'h0000007F);
    check(32'h0, 32'(cmp_en[7]));
    wr(rvm_pkg::OFS_SECURE, 32'h00000000);
  endtask
  // ==========================================================================
  // Main sequence; channels settle before the monitor scenarios start.
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    t_reset();
    t_trip();
    cyc(int'(rvm_pkg::SETTLE_C) + 100);
    t_low();
    t_high();
    t_disable();
    t_gate();
    t_secure();
    summarize();
  end
  // Watchdog, well beyond the roughly 3800 cycles the scenarios need.
  initial begin
    cyc(30000);
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
